// ===== rtl/otpm_regs.svh
// Constants for the one-time-programmable memory command block
`ifndef OTPM_REGS_SVH
`define OTPM_REGS_SVH

// Function commands
`define OTPM_CMD_SKIP      8'hcc
`define OTPM_CMD_RD_PAGE   8'hc3
`define OTPM_CMD_RD_FIELD  8'hf0
`define OTPM_CMD_WRITE     8'h0f
`define OTPM_CMD_PROG      8'h5a

// CRC generator, reflected form of x^8 + x^5 + x^4 + 1
`define OTPM_CRC_POLY      8'h8c
`define OTPM_CRC_INIT      8'h00

// Field geometry
`define OTPM_FIELD_BYTES   128
`define OTPM_LAST_ADDR     7'h7f
`define OTPM_PAGE_END      5'h1f
`define OTPM_SEG_LAST      3'h7
`define OTPM_BIT_LAST      3'h7
`define OTPM_BLANK_BYTE    8'hff

// Timing
`define OTPM_CLK_MHZ       200
`define OTPM_PROG_TIME_US  2500

`endif

// ===== rtl/otpm_pkg.sv
// Types shared by the one-time-programmable memory command block
`default_nettype none

package otpm_pkg;

	typedef enum logic [3:0] {
		ST_ROM   = 4'h0,
		ST_CMD   = 4'h1,
		ST_ALO   = 4'h2,
		ST_AHI   = 4'h3,
		ST_ACRC  = 4'h4,
		ST_DATA  = 4'h5,
		ST_PCRC  = 4'h6,
		ST_FCRC  = 4'h7,
		ST_ONES  = 4'h8,
		ST_WDATA = 4'h9,
		ST_WCRC  = 4'ha,
		ST_PCMD  = 4'hb,
		ST_PROG  = 4'hc,
		ST_VERI  = 4'hd,
		ST_IDLE  = 4'he
	} otpm_state_e;

	typedef enum logic [1:0] {
		MODE_PAGE  = 2'h0,
		MODE_FIELD = 2'h1,
		MODE_WRITE = 2'h2
	} otpm_mode_e;

endpackage

`default_nettype wire

// ===== rtl/otpm_core.sv
// Command engine of the one-time-programmable 1024-bit data field
//
// What this block does
// - Command C3h then address low and high byte starts page-check read.
// - After read command and address, device sends CRC of all three bytes.
// - Page-check read sends data to page end, then that page's CRC.
// - After each page CRC but the last, next page follows; 32 data bytes per page.
// - Address and data bytes travel least significant bit first.
// - Command F0h then address low and high byte starts field-check read.
// - Field-check read streams to field end, then CRC over all data bytes sent.
// - After the field CRC every read slot returns one until reset.
// - Reset before field end discards the read, no CRC given.
// - Command 0Fh plus address; device answers CRC of command and address.
// - Host sends eight bytes into buffer; device answers their CRC.
// - Programming ANDs each of eight memory bytes with its buffer byte.
// - Reset aborts a write anywhere except during the programming pulse.
// - After programming, device returns programmed contents, LSB first.
// - Device cannot judge host CRC; it simply follows the host.
// - Unprogrammed field bits read as one.
// - Programming acts on one 8-byte segment per operation.
// - Memory commands are accepted only right after skip command CCh.
// - All CRC bytes use polynomial x^8 + x^5 + x^4 + 1.
`default_nettype none
`include "otpm_regs.svh"

module otpm_core #(
	parameter int PROG_CYC = `OTPM_PROG_TIME_US * `OTPM_CLK_MHZ
) (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic line_reset,
	input  wire logic slot_wr,
	input  wire logic slot_bit,
	input  wire logic slot_rd,
	input  wire logic prog_level_pin,
	output logic      rd_bit,
	output logic      presence_pulse
);

	localparam int PCW = $clog2(PROG_CYC + 1);

	otpm_pkg::otpm_state_e st_q, st_d;
	otpm_pkg::otpm_mode_e  mode_q, mode_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0]  crc_q, crc_d;
	logic [7:0]  tx_q, tx_d;
	logic [7:0]  rx_q, rx_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [2:0]  bcnt_q, bcnt_d;
	logic [PCW-1:0] pcnt_q;
	logic [7:0]  mem_q [`OTPM_FIELD_BYTES];
	logic [7:0]  buf_q [8];
	logic [7:0]  prog_val [8];
	logic        prog_m_q, prog_s_q, prog_p_q;
	logic        presence_q;
	logic        commit;
	logic        buf_wr;

	////////////////////////////////////////////////////////////////////////
	// Decode

	wire       is_rx = (st_q == otpm_pkg::ST_ROM) || (st_q == otpm_pkg::ST_CMD)
		|| (st_q == otpm_pkg::ST_ALO) || (st_q == otpm_pkg::ST_AHI)
		|| (st_q == otpm_pkg::ST_WDATA) || (st_q == otpm_pkg::ST_PCMD);
	wire       is_tx = (st_q == otpm_pkg::ST_ACRC) || (st_q == otpm_pkg::ST_DATA)
		|| (st_q == otpm_pkg::ST_PCRC) || (st_q == otpm_pkg::ST_FCRC)
		|| (st_q == otpm_pkg::ST_WCRC) || (st_q == otpm_pkg::ST_VERI)
		|| (st_q == otpm_pkg::ST_ONES);
	wire [7:0] rx_full = {slot_bit, rx_q[7:1]};
	wire       rx_done = slot_wr && is_rx && (cnt_q == `OTPM_BIT_LAST);
	wire       tx_done = slot_rd && is_tx && (cnt_q == `OTPM_BIT_LAST);
	wire [15:0] addr_inc = addr_q + 16'h0001;
	wire [6:0] idx = addr_q[6:0];
	wire [6:0] idx_inc = addr_inc[6:0];
	wire [3:0] seg = addr_q[6:3];
	wire       at_end = (idx == `OTPM_LAST_ADDR);
	wire       at_page_end = (addr_q[4:0] == `OTPM_PAGE_END);
	wire       prog_fall = prog_p_q && !prog_s_q;
	// A reset is refused only while the programming level stands
	wire       reset_ok = line_reset
		&& !((st_q == otpm_pkg::ST_PROG) && prog_s_q);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_seg
			assign prog_val[gi] = mem_q[{seg, 3'(gi)}] & buf_q[gi];
		end
	endgenerate

	function automatic logic [7:0] crc_bit(input logic [7:0] c,
	                                       input logic       b);
		logic fb;
		fb = c[0] ^ b;
		crc_bit = {1'b0, c[7:1]} ^ (fb ? `OTPM_CRC_POLY : 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;
		mode_d = mode_q;
		addr_d = addr_q;
		crc_d = crc_q;
		tx_d = tx_q;
		rx_d = rx_q;
		cnt_d = cnt_q;
		bcnt_d = bcnt_q;
		commit = 1'b0;
		buf_wr = 1'b0;
		if (slot_wr && is_rx) begin
			rx_d = rx_full;
			cnt_d = cnt_q + 3'h1;
			if (st_q != otpm_pkg::ST_ROM && st_q != otpm_pkg::ST_PCMD)
				crc_d = crc_bit(crc_q, slot_bit);
		end
		if (slot_rd && is_tx) begin
			tx_d = {1'b1, tx_q[7:1]};
			cnt_d = cnt_q + 3'h1;
			if (st_q == otpm_pkg::ST_DATA)
				crc_d = crc_bit(crc_q, tx_q[0]);
		end
		case (st_q)
			otpm_pkg::ST_ROM: if (rx_done) begin
				if (rx_full == `OTPM_CMD_SKIP) begin
					st_d = otpm_pkg::ST_CMD;
					crc_d = `OTPM_CRC_INIT;
				end else begin
					st_d = otpm_pkg::ST_IDLE;
				end
			end
			otpm_pkg::ST_CMD: if (rx_done) begin
				st_d = otpm_pkg::ST_ALO;
				case (rx_full)
					`OTPM_CMD_RD_PAGE:  mode_d = otpm_pkg::MODE_PAGE;
					`OTPM_CMD_RD_FIELD: mode_d = otpm_pkg::MODE_FIELD;
					`OTPM_CMD_WRITE:    mode_d = otpm_pkg::MODE_WRITE;
					default:            st_d = otpm_pkg::ST_IDLE;
				endcase
			end
			otpm_pkg::ST_ALO: if (rx_done) begin
				addr_d[7:0] = rx_full;
				st_d = otpm_pkg::ST_AHI;
			end
			otpm_pkg::ST_AHI: if (rx_done) begin
				addr_d[15:8] = rx_full;
				tx_d = crc_d;
				st_d = otpm_pkg::ST_ACRC;
			end
			otpm_pkg::ST_ACRC: if (tx_done) begin
				crc_d = `OTPM_CRC_INIT;
				bcnt_d = 3'h0;
				if (mode_q == otpm_pkg::MODE_WRITE) begin
					st_d = otpm_pkg::ST_WDATA;
				end else begin
					tx_d = mem_q[idx];
					st_d = otpm_pkg::ST_DATA;
				end
			end
			otpm_pkg::ST_DATA: if (tx_done) begin
				// page end brings the page CRC
				if (mode_q == otpm_pkg::MODE_PAGE && at_page_end) begin
					tx_d = crc_d;
					st_d = otpm_pkg::ST_PCRC;
				// field end brings the field CRC
				end else if (at_end) begin
					tx_d = crc_d;
					st_d = otpm_pkg::ST_FCRC;
				end else begin
					addr_d = addr_inc;
					tx_d = mem_q[idx_inc];
				end
			end
			otpm_pkg::ST_PCRC: if (tx_done) begin
				if (at_end) begin
					tx_d = `OTPM_BLANK_BYTE;
					st_d = otpm_pkg::ST_ONES;
				end else begin
					addr_d = addr_inc;
					crc_d = `OTPM_CRC_INIT;
					tx_d = mem_q[idx_inc];
					st_d = otpm_pkg::ST_DATA;
				end
			end
			otpm_pkg::ST_FCRC: if (tx_done) begin
				tx_d = `OTPM_BLANK_BYTE;
				st_d = otpm_pkg::ST_ONES;
			end
			otpm_pkg::ST_ONES: tx_d = `OTPM_BLANK_BYTE;
			otpm_pkg::ST_WDATA: if (rx_done) begin
				buf_wr = 1'b1;
				bcnt_d = bcnt_q + 3'h1;
				if (bcnt_q == `OTPM_SEG_LAST) begin
					tx_d = crc_d;
					st_d = otpm_pkg::ST_WCRC;
				end
			end
			// proceed whatever the host's CRC says
			otpm_pkg::ST_WCRC: if (tx_done) st_d = otpm_pkg::ST_PCMD;
			otpm_pkg::ST_PCMD: if (rx_done) begin
				st_d = (rx_full == `OTPM_CMD_PROG) ? otpm_pkg::ST_PROG
					: otpm_pkg::ST_IDLE;
			end
			otpm_pkg::ST_PROG: if (prog_fall) begin
				commit = (pcnt_q >= PCW'(PROG_CYC));
				bcnt_d = 3'h0;
				cnt_d = 3'h0;
				tx_d = commit ? prog_val[0] : mem_q[{seg, 3'h0}];
				st_d = otpm_pkg::ST_VERI;
			end
			otpm_pkg::ST_VERI: if (tx_done) begin
				bcnt_d = bcnt_q + 3'h1;
				if (bcnt_q == `OTPM_SEG_LAST) begin
					tx_d = `OTPM_BLANK_BYTE;
					st_d = otpm_pkg::ST_ONES;
				end else begin
					tx_d = mem_q[{seg, bcnt_q + 3'h1}];
				end
			end
			otpm_pkg::ST_IDLE: tx_d = `OTPM_BLANK_BYTE;
			default: st_d = otpm_pkg::ST_ROM;
		endcase
		if (reset_ok) begin
			st_d = otpm_pkg::ST_ROM;
			cnt_d = 3'h0;
			tx_d = `OTPM_BLANK_BYTE;
			crc_d = `OTPM_CRC_INIT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= otpm_pkg::ST_ROM;
			mode_q <= otpm_pkg::MODE_PAGE;
			addr_q <= 16'h0000;
			crc_q <= `OTPM_CRC_INIT;
			tx_q <= `OTPM_BLANK_BYTE;
			rx_q <= 8'h00;
			cnt_q <= 3'h0;
			bcnt_q <= 3'h0;
		end else begin
			st_q <= st_d;
			mode_q <= mode_d;
			addr_q <= addr_d;
			crc_q <= crc_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			cnt_q <= cnt_d;
			bcnt_q <= bcnt_d;
		end
	end

	// Programming level is a pin: synchronise before use
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prog_m_q <= 1'b0;
			prog_s_q <= 1'b0;
			prog_p_q <= 1'b0;
			presence_q <= 1'b0;
		end else begin
			prog_m_q <= prog_level_pin;
			prog_s_q <= prog_m_q;
			prog_p_q <= prog_s_q;
			presence_q <= reset_ok;
		end
	end

	// Pulse width counter, saturating so long pulses do not wrap
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			pcnt_q <= '0;
		else if (st_q != otpm_pkg::ST_PROG || !prog_s_q)
			pcnt_q <= '0;
		else if (pcnt_q != PCW'(PROG_CYC))
			pcnt_q <= pcnt_q + PCW'(1);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int j = 0; j < 8; j++)
				buf_q[j] <= `OTPM_BLANK_BYTE;
		end else if (buf_wr) begin
			buf_q[bcnt_q] <= rx_full;
		end
	end

	// Power-up stands in for an erased part; arst_n is a power-on reset
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int j = 0; j < `OTPM_FIELD_BYTES; j++)
				mem_q[j] <= `OTPM_BLANK_BYTE;
		end else if (commit) begin
			for (int j = 0; j < 8; j++)
				mem_q[{seg, 3'(j)}] <= prog_val[j];
		end
	end

	assign rd_bit = tx_q[0];
	assign presence_pulse = presence_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	skip_gate_a: assert property (st_q == otpm_pkg::ST_ROM && rx_done
		&& rx_full != `OTPM_CMD_SKIP && !line_reset
		|=> st_q == otpm_pkg::ST_IDLE) else $error("non-skip accepted");
	crc_clear_a: assert property (st_q == otpm_pkg::ST_ROM && rx_done
		&& rx_full == `OTPM_CMD_SKIP && !line_reset
		|=> st_q == otpm_pkg::ST_CMD && crc_q == 8'h00)
		else $error("crc not cleared");
	page_crc_a: assert property (st_q == otpm_pkg::ST_DATA && tx_done
		&& mode_q == otpm_pkg::MODE_PAGE && at_page_end && !line_reset
		|=> st_q == otpm_pkg::ST_PCRC && tx_q == $past(crc_d))
		else $error("page crc missing");
	next_page_a: assert property (st_q == otpm_pkg::ST_PCRC && tx_done
		&& !at_end && !line_reset
		|=> st_q == otpm_pkg::ST_DATA && crc_q == 8'h00
		&& addr_q == $past(addr_q) + 16'h0001)
		else $error("next page wrong");
	field_end_a: assert property (st_q == otpm_pkg::ST_DATA && tx_done
		&& mode_q == otpm_pkg::MODE_FIELD && at_end && !line_reset
		|=> st_q == otpm_pkg::ST_FCRC) else $error("field crc missing");
	ones_a: assert property (st_q == otpm_pkg::ST_ONES
		|-> rd_bit ##1 (rd_bit || st_q != otpm_pkg::ST_ONES))
		else $error("ones not sent");
	reset_abort_a: assert property (reset_ok
		|=> st_q == otpm_pkg::ST_ROM && rd_bit) else $error("reset ignored");
	prog_hold_a: assert property (st_q == otpm_pkg::ST_PROG && prog_s_q
		&& line_reset |=> st_q == otpm_pkg::ST_PROG && !presence_pulse)
		else $error("reset during pulse");
	wdata_cnt_a: assert property (st_q == otpm_pkg::ST_WDATA && rx_done
		&& bcnt_q == `OTPM_SEG_LAST && !line_reset
		|=> st_q == otpm_pkg::ST_WCRC) else $error("write count wrong");
	and_prog_a: assert property (commit
		|=> mem_q[{$past(seg), 3'h0}] == $past(prog_val[0])
		&& rd_bit == $past(prog_val[0][0])) else $error("and programming");

endmodule

`default_nettype wire

// ===== verification/otpm_host.sv
// Host controller model driving the slot link of the memory core
`default_nettype none

module otpm_host (
	input  wire logic ref_clk,
	output logic      line_reset,
	output logic      slot_wr,
	output logic      slot_bit,
	output logic      slot_rd,
	output logic      prog_level_pin,
	input  wire logic rd_bit,
	input  wire logic presence_pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		line_reset = 1'b0;
		slot_wr = 1'b0;
		slot_bit = 1'b0;
		slot_rd = 1'b0;
		prog_level_pin = 1'b0;
	end

	task automatic bus_reset(output logic pres);
		@(posedge ref_clk);
		line_reset <= 1'b1;
		@(posedge ref_clk);
		line_reset <= 1'b0;
		// Presence stands for one cycle only: look while it is settled
		@(negedge ref_clk);
		pres = presence_pulse;
	endtask

	// LSB first each byte
	// Idle data level is the inverse, so a stale bit is never reused
	task automatic put_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			slot_wr <= 1'b1;
			slot_bit <= b[i];
			@(posedge ref_clk);
			slot_wr <= 1'b0;
			slot_bit <= ~b[i];
		end
	endtask

	task automatic get_byte(output logic [7:0] b);
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			b[i] = rd_bit;
			slot_rd <= 1'b1;
			@(posedge ref_clk);
			slot_rd <= 1'b0;
		end
	endtask

	task automatic open_cmd(input logic [7:0] skip, input logic [7:0] cmd,
		input logic [7:0] a, output logic pres);
		bus_reset(pres);
		put_byte(skip);
		put_byte(cmd);
		put_byte(a);
		put_byte(8'h00);
	endtask

	// level held for n/2 + 1 + n/2 cycles; optional reset inside
	task automatic prog_pulse(input int n, input logic rst, output logic pres);
		@(posedge ref_clk);
		prog_level_pin <= 1'b1;
		repeat (n / 2) @(posedge ref_clk);
		line_reset <= rst;
		@(posedge ref_clk);
		line_reset <= 1'b0;
		@(negedge ref_clk);
		pres = presence_pulse;
		repeat (n / 2) @(posedge ref_clk);
		prog_level_pin <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask
endmodule

`default_nettype wire

// ===== verification/tb_otp_memory_read_write_commands.sv
// Self-checking bench for the memory command core
`default_nettype none

module tb_otp_memory_read_write_commands;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int PROG = 20;

	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] addr;
		logic [7:0] n;
	} otpm_row_s;

	logic       ref_clk;
	logic       arst_n;
	logic       line_reset;
	logic       slot_wr;
	logic       slot_bit;
	logic       slot_rd;
	logic       prog_level_pin;
	logic       rd_bit;
	logic       presence_pulse;
	logic       pres;
	logic [7:0] got;
	logic [7:0] crc;
	logic [7:0] mem [128];
	int         errors = 0;
	int         checks_done = 0;
	otpm_row_s  rows [4] = '{'{8'hc3, 8'h1e, 8'h03}, '{8'hf0, 8'h7e, 8'h02},
		'{8'hc3, 8'h7f, 8'h01}, '{8'hf0, 8'h00, 8'h03}};

	otpm_core #(.PROG_CYC(PROG)) u_otpm_core (
		.ref_clk(ref_clk), .arst_n(arst_n), .line_reset(line_reset),
		.slot_wr(slot_wr), .slot_bit(slot_bit), .slot_rd(slot_rd),
		.prog_level_pin(prog_level_pin), .rd_bit(rd_bit),
		.presence_pulse(presence_pulse));

	otpm_host u_otpm_host (
		.ref_clk(ref_clk), .line_reset(line_reset), .slot_wr(slot_wr),
		.slot_bit(slot_bit), .slot_rd(slot_rd),
		.prog_level_pin(prog_level_pin), .rd_bit(rd_bit),
		.presence_pulse(presence_pulse));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// reflected x^8 + x^5 + x^4 + 1
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
		return c;
	endfunction

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		checks_done++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			errors++;
		end
	endtask

	task automatic rd_chk(input string what, input logic [7:0] exp);
		u_otpm_host.get_byte(got);
		chk(what, exp, got);
	endtask

	// CRC starts from zero at command and at each block
	task automatic start(input logic [7:0] cmd, input logic [7:0] a);
		u_otpm_host.open_cmd(8'hcc, cmd, a, pres);
		chk("presence", 8'h01, {7'h00, pres});
		crc = crc8(crc8(crc8(8'h00, cmd), a), 8'h00);
		rd_chk("command crc", crc);
		crc = 8'h00;
	endtask

	task automatic read_run(input logic [7:0] cmd, input logic [7:0] a,
		input int n);
		for (int k = 0; k < n; k++) begin
			rd_chk("data", mem[a[6:0]]);
			crc = crc8(crc, mem[a[6:0]]);
			if (cmd == 8'hc3 && a[4:0] == 5'h1f) begin
				rd_chk("page crc", crc);
				crc = 8'h00;
			end
			if (cmd == 8'hf0 && a == 8'h7f)
				rd_chk("field crc", crc);
			a++;
		end
	endtask

	// Second write to a segment must only clear bits, never set them
	task automatic write_seg(input logic [7:0] a, input logic [63:0] d,
		input int n);
		start(8'h0f, a);
		for (int k = 0; k < 8; k++) begin
			u_otpm_host.put_byte(d[8*k +: 8]);
			crc = crc8(crc, d[8*k +: 8]);
		end
		rd_chk("data crc", crc);
		u_otpm_host.put_byte(8'h5a);
		u_otpm_host.prog_pulse(n, 1'b1, pres);
		chk("presence in pulse", 8'h00, {7'h00, pres});
		for (int k = 0; k < 8; k++) begin
			// A pulse well short of the minimum must leave memory alone
			if (n >= PROG)
				mem[a + k] = mem[a + k] & d[8*k +: 8];
			rd_chk("verify", mem[a + k]);
		end
		rd_chk("after verify", 8'hff);
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#200us;
		errors++;
		stop_test();
	end

	initial begin
		arst_n = 1'b0;
		foreach (mem[i]) mem[i] = 8'hff;
		repeat (2) @(posedge ref_clk);
		chk("rd_bit in reset", 8'h01, {7'h00, rd_bit});
		arst_n <= 1'b1;
		// each row ends the previous read by a line reset
		foreach (rows[i]) begin
			start(rows[i].cmd, rows[i].addr);
			read_run(rows[i].cmd, rows[i].addr, int'(rows[i].n));
			got = rows[i].addr + rows[i].n;
			rd_chk("next", got > 8'h7f ? 8'hff : mem[got]);
			$display("read row %0d done", i);
		end
		write_seg(8'h08, 64'h0123456789abcdef, PROG + 4);
		write_seg(8'h08, 64'hf0f0f0f0f0f0f0f0, PROG + 4);
		write_seg(8'h78, 64'h00ff55aa3c3cc3c3, PROG + 4);
		write_seg(8'h10, 64'h0000000000000000, 8);
		$display("write test done");
		start(8'hf0, 8'h00);
		read_run(8'hf0, 8'h00, 128);
		rd_chk("ones after field", 8'hff);
		start(8'hc3, 8'h00);
		read_run(8'hc3, 8'h00, 128);
		rd_chk("ones after pages", 8'hff);
		$display("full read test done");
		u_otpm_host.open_cmd(8'h33, 8'hf0, 8'h00, pres);
		rd_chk("no skip", 8'hff);
		u_otpm_host.open_cmd(8'hcc, 8'haa, 8'h00, pres);
		rd_chk("bad command", 8'hff);
		$display("refusal test done");
		stop_test();
	end
endmodule

`default_nettype wire
